// ===== testbench/digipot_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module digipot_device_model #(
	parameter logic [1:0] STRAP = 2'h2,
	parameter logic [7:0] TOL = 8'h3C
) (
	input wire logic scl,
	input wire logic sda,
	output logic pull
);
	logic [7:0] sh, rd, wiper, nvs;
	logic [6:0] own;
	logic [2:0] cmd;
	logic act, rw, prot, nvread, mack, drv;
	int bc, nb;
	initial begin
		case (STRAP)
			2'h0: own = 7'h18;
			2'h2: own = 7'h1A;
			2'h1: own = 7'h4C;
			default: own = 7'h4E;
		endcase
		{pull, act, rw, prot, nvread, mack, drv, cmd, sh, rd} = '0;
		wiper = 8'h80;
		nvs = 8'h80;
		bc = 0;
		nb = 0;
	end
	always @(negedge sda) if (scl === 1'b1) begin
		act = 1;
		drv = 0;
		bc = 0;
		nb = 0;
	end
	always @(posedge sda) if (scl === 1'b1) act = 0;
	always @(posedge scl) if (act) begin
		if (bc < 8) sh = {sh[6:0], sda};
		if (bc == 8) mack = !sda;
		bc++;
	end
	always @(negedge scl) if (act) begin
		if (bc == 8) begin
			pull = 0;
			if (nb == 0) begin
				rw = sh[0];
				act = (sh[7:1] == own);
				pull = act;
			end else if (!rw) begin
				pull = 1;
				if (nb == 1) begin
					cmd = sh[7:5];
					if (cmd == 3'h6 && !prot) nvs = wiper;
					if (cmd == 3'h5) {nvread, wiper} = {1'b1, nvs};
					if (cmd == 3'h4) nvread = 0;
				end else if (cmd == 3'h2) prot = sh[0];
				else if (!prot && cmd == 3'h0) wiper = sh;
				else if (!prot && cmd == 3'h1) nvs = sh;
			end
			nb++;
		end else if (bc == 9) begin
			bc = 0;
			drv = rw && (nb == 1 || mack);
			rd = (cmd == 3'h0) ? wiper : (cmd == 3'h1) ? nvs : TOL;
			pull = drv && !rd[7];
		end else if (drv) pull = !rd[7 - bc];
	end
endmodule
`default_nettype wire

// ===== testbench/digipot_host_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module digipot_host_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl,
	input wire logic sda_o,
	input wire logic sda_oe
);
	logic [11:0] hi_q;
	logic [11:0] lo_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// saturating, so a long idle bus cannot wrap back to a small count
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_q <= 12'h000;
			lo_q <= 12'h000;
		end else begin
			hi_q <= scl ? hi_q + {11'h000, ~&hi_q} : 12'h000;
			lo_q <= scl ? 12'h000 : lo_q + {11'h000, ~&lo_q};
		end
	end
	property p_wait_state;
		psel && !penable |-> ##2 pready;
	endproperty
	a_wait_state: assert property (p_wait_state) else $error("pready not two cycles after setup");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_err_decode;
		pready |-> pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0);
	endproperty
	a_err_decode: assert property (p_err_decode) else $error("pslverr does not match address map");
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
	property p_open_drain;
		!sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven high");
	property p_start_hold;
		$rose(sda_oe) && scl |=> scl [*8];
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("scl dropped right after start");
	property p_stop_idle;
		$fell(sda_oe) && scl |=> (scl && !sda_oe) [*8];
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
	property p_scl_high;
		$fell(scl) |-> hi_q >= 12'h190;
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
	property p_scl_low;
		$rose(scl) |-> lo_q >= 12'h190;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
endmodule
bind digipot_host digipot_host_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .scl(scl),
	.sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic ref_clk, rst_n, psel, penable, pwrite, err, pready, pslverr, scl, sda_o, sda_oe, pull;
	logic [7:0] paddr, w;
	logic [31:0] pwdata, prdata, rdat;
	wire logic sda_i;
	int n_errors, samples_checked;
	logic [7:0] exp_q[$];
	// released line floats high through the pull-up
	assign sda_i = !(sda_oe || pull);
	digipot_host dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
	digipot_device_model dev (.scl(scl), .sda(sda_i), .pull(pull));
	task automatic complete_run();
		if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge ref_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		t = 0;
		// read at the falling edge: the values have settled for the rising edge that ends the access
		do begin
			@(negedge ref_clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rdat = prdata;
		err = pslverr;
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (t >= 20) begin
			check(32'h0, 32'h1);
			complete_run();
		end
	endtask
	// drains each received byte as it lands, so the link never stalls for long
	task automatic wait_idle();
		logic [31:0] s;
		for (int i = 0; i < 30000; i++) begin
			apb(1'b0, 8'h08, 32'h0);
			s = rdat;
			if (s[3] === 1'b1) begin
				apb(1'b0, 8'h0C, 32'h0);
				check(rdat, exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 32'hFFFFFFFF);
			end
			if (s[0] === 1'b0) return;
		end
		check(32'h0, 32'h1);
		complete_run();
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		n_errors = 0;
		samples_checked = 0;
		void'($urandom(94));
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int a = 0; a < 16; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			check(rdat, 32'h0);
		end
		apb(1'b1, 8'h10, 32'h5A);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 8'h12, 32'h0);
		check({err, rdat[30:0]}, 32'h80000000);
		// data byte shaped like a protect instruction must still land in the wiper
		w = {3'h2, 5'($urandom)};
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, 8'h0C, {24'h0, w});
		apb(1'b0, 8'h08, 32'h0);
		check(rdat, 32'h00000004);
		apb(1'b1, 8'h00, 32'h008);
		apb(1'b1, 8'h00, 32'h03F);
		apb(1'b0, 8'h00, 32'h0);
		check(rdat, 32'h008);
		wait_idle();
		check({24'h0, dev.wiper}, {24'h0, w});
		exp_q = '{w, w};
		apb(1'b1, 8'h00, 32'h110);
		wait_idle();
		check(32'(exp_q.size()), 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		check({31'h0, rdat[1]}, 32'h0);
		apb(1'b1, 8'h04, 32'h3);
		// a restore that is not acknowledged must not be chased by a no-operation
		apb(1'b1, 8'h00, 32'h005);
		wait_idle();
		apb(1'b0, 8'h08, 32'h0);
		check({31'h0, rdat[1]}, 32'h1);
		check({27'h0, rdat[4:0]}, 32'h00000002);
		check({31'h0, dev.nvread}, 32'h0);
		check({24'h0, dev.wiper}, {24'h0, w});
		complete_run();
	end
endmodule
`default_nettype wire

// ===== verilog/_end_marker_unused.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== verilog/bit_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bit_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic meta;
		logic stable;
	} sync_t;

	sync_t q;
	sync_t d;

	always_comb begin
		d.meta = din;
		d.stable = q.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dout = q.stable;
endmodule
`default_nettype wire

// ===== verilog/digipot_host.sv
// How it works
// - every transfer opens with sda falling while scl is high
// - first byte is 7-bit address plus direction, high meaning read
// - write's second byte: three command bits, five zero bits, acknowledged
// - third write byte is data, msb first, acknowledged on ninth pulse
// - store and restore send only address and instruction, no data
// - controller follows each restore with a no-operation command; here not after a restore that was not acknowledged
// - reading another register: write address and instruction, repeated start
// - every transfer ends with sda rising while scl is high
// - write stop: sda rises during tenth pulse after final acknowledge
// - read: no-acknowledge on ninth pulse, sda low, then stop
// - data bytes are never instructions; new instruction needs new transfer
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module digipot_host (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	typedef struct packed {
		digipot_host_pkg::state_t st;
		digipot_host_pkg::step_t step;
		logic [1:0] ph;
		logic [8:0] tick;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic [3:0] left;
		logic scl;
		logic sda_oe;
		logic sda_o;
		logic [11:0] cmd;
		logic [1:0] sel;
		logic [7:0] tx;
		logic tx_full;
		logic [7:0] rx;
		logic rx_full;
		logic nack;
		logic auto_nop;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} regs_t;

	regs_t q;
	regs_t n;
	logic rst_sync_n;
	logic sda_s;
	logic tick_end;
	logic apb_take;
	logic mapped;

	bit_sync u_rst_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.din(1'b1),
		.dout(rst_sync_n)
	);

	bit_sync u_sda_sync (
		.clk(ref_clk),
		.rst_n(rst_sync_n),
		.din(sda_i),
		.dout(sda_s)
	);

	// start a byte with scl low: first bit goes onto sda right away
	function automatic regs_t enter_byte(input regs_t r, input logic [7:0] v,
			input digipot_host_pkg::step_t s);
		regs_t o;
		o = r;
		o.st = digipot_host_pkg::ST_BYTE;
		o.step = s;
		o.ph = 2'h0;
		o.tick = 9'h000;
		o.bitn = 4'h0;
		o.shreg = v;
		o.sda_oe = (s == digipot_host_pkg::STEP_READ) ? 1'b0 : ~v[7];
		return o;
	endfunction

	function automatic regs_t enter_cond(input regs_t r, input digipot_host_pkg::state_t s);
		regs_t o;
		o = r;
		o.st = s;
		o.ph = 2'h0;
		o.tick = 9'h000;
		o.sda_oe = (s == digipot_host_pkg::ST_STOP);
		return o;
	endfunction

	// data bytes wait for software; scl is held low meanwhile
	function automatic regs_t enter_wait(input regs_t r, input digipot_host_pkg::step_t s);
		regs_t o;
		o = r;
		o.st = digipot_host_pkg::ST_WAIT;
		o.step = s;
		o.sda_oe = 1'b0;
		return o;
	endfunction

	always_comb begin
		n = q;
		tick_end = (q.tick == digipot_host_pkg::QUARTER_LAST);
		apb_take = psel & penable & q.pready;
		mapped = (paddr == digipot_host_pkg::OFF_CMD) || (paddr == digipot_host_pkg::OFF_SEL) ||
			(paddr == digipot_host_pkg::OFF_STATUS) || (paddr == digipot_host_pkg::OFF_DATA);

		// register read: one wait state, data and error registered
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !q.pready) begin
			n.pready = 1'b1;
			n.pslverr = ~mapped;
			case (paddr)
				digipot_host_pkg::OFF_CMD: n.prdata = {20'h00000, q.cmd};
				digipot_host_pkg::OFF_SEL: n.prdata = {30'h00000000, q.sel};
				digipot_host_pkg::OFF_STATUS: begin
					n.prdata = 32'h00000000;
					n.prdata[digipot_host_pkg::STAT_BUSY] = (q.st != digipot_host_pkg::ST_IDLE);
					n.prdata[digipot_host_pkg::STAT_NACK] = q.nack;
					n.prdata[digipot_host_pkg::STAT_TXF] = q.tx_full;
					n.prdata[digipot_host_pkg::STAT_RXF] = q.rx_full;
					n.prdata[digipot_host_pkg::STAT_AUTO] = q.auto_nop;
					n.prdata[digipot_host_pkg::STAT_RX_LSB +: 8] = q.rx;
				end
				digipot_host_pkg::OFF_DATA: n.prdata = {24'h000000, q.rx};
				default: n.prdata = 32'h00000000;
			endcase
		end

		// the read clear comes first so a byte landing in the same cycle keeps its flag
		if (apb_take && !pwrite && paddr == digipot_host_pkg::OFF_DATA) begin
			n.rx_full = 1'b0;
		end

		if (q.st != digipot_host_pkg::ST_IDLE && q.st != digipot_host_pkg::ST_WAIT) begin
			n.tick = tick_end ? 9'h000 : q.tick + 9'h001;
			if (tick_end) begin
				n.ph = q.ph + 2'h1;
			end
		end

		case (q.st)
			digipot_host_pkg::ST_IDLE: begin
				n.scl = 1'b1;
				n.sda_oe = 1'b0;
			end
			digipot_host_pkg::ST_START: begin
				if (tick_end) begin
					case (q.ph)
						2'h0: n.scl = 1'b1;
						2'h1: n.sda_oe = 1'b1;
						2'h2: n.scl = 1'b0;
						default: begin
							if (q.step == digipot_host_pkg::STEP_ADDR_R) begin
								n = enter_byte(n, {digipot_host_pkg::dev_addr(q.sel),
									digipot_host_pkg::RW_READ}, q.step);
							end else begin
								n = enter_byte(n, {digipot_host_pkg::dev_addr(q.sel),
									digipot_host_pkg::RW_WRITE}, q.step);
							end
						end
					endcase
				end
			end
			digipot_host_pkg::ST_BYTE: begin
				if (tick_end) begin
					case (q.ph)
						2'h0: n.scl = 1'b1;
						2'h1: n.scl = 1'b1;
						2'h2: begin
							// sample at the end of the high half, as scl falls; the device moves its bit after scl falls
							n.scl = 1'b0;
							if (q.bitn != digipot_host_pkg::ACK_BIT) begin
								if (q.step == digipot_host_pkg::STEP_READ) begin
									n.shreg = {q.shreg[6:0], sda_s};
								end else begin
									n.shreg = {q.shreg[6:0], 1'b0};
								end
								if (q.step == digipot_host_pkg::STEP_READ &&
										q.bitn == digipot_host_pkg::LAST_DATA_BIT) begin
									n.rx = {q.shreg[6:0], sda_s};
									n.rx_full = 1'b1;
								end
							end else if (q.step != digipot_host_pkg::STEP_READ) begin
								n.shreg[0] = sda_s;
							end
						end
						default: begin
							if (q.bitn != digipot_host_pkg::ACK_BIT) begin
								n.bitn = q.bitn + 4'h1;
								if (q.step == digipot_host_pkg::STEP_READ) begin
									// ack every byte but the last, which gets no_acknowledge
									n.sda_oe = (q.bitn == digipot_host_pkg::LAST_DATA_BIT) &&
										(q.left != 4'h0);
								end else begin
									n.sda_oe = (q.bitn == digipot_host_pkg::LAST_DATA_BIT) ?
										1'b0 : ~q.shreg[7];
								end
							end else if (q.step != digipot_host_pkg::STEP_READ && q.shreg[0]) begin
								n.nack = 1'b1;
								n = enter_cond(n, digipot_host_pkg::ST_STOP);
							end else begin
								case (q.step)
									digipot_host_pkg::STEP_ADDR_W: begin
										n = enter_byte(n, {q.cmd[digipot_host_pkg::CMD_CODE_LSB +: 3],
											digipot_host_pkg::INSTR_PAD}, digipot_host_pkg::STEP_INSTR);
									end
									digipot_host_pkg::STEP_INSTR: begin
										if (q.cmd[digipot_host_pkg::CMD_DATA_BIT]) begin
											n = enter_wait(n, digipot_host_pkg::STEP_DATA);
										end else if (q.cmd[digipot_host_pkg::CMD_READ_BIT]) begin
											n.step = digipot_host_pkg::STEP_ADDR_R;
											n = enter_cond(n, digipot_host_pkg::ST_START);
										end else begin
											n = enter_cond(n, digipot_host_pkg::ST_STOP);
										end
									end
									digipot_host_pkg::STEP_ADDR_R: begin
										n = enter_wait(n, digipot_host_pkg::STEP_READ);
									end
									default: begin
										// further bytes stay data under the same instruction
										if (q.left != 4'h0) begin
											n.left = q.left - 4'h1;
											n = enter_wait(n, q.step);
										end else begin
											n = enter_cond(n, digipot_host_pkg::ST_STOP);
										end
									end
								endcase
							end
						end
					endcase
				end
			end
			digipot_host_pkg::ST_WAIT: begin
				n.scl = 1'b0;
				if (q.step == digipot_host_pkg::STEP_DATA && q.tx_full) begin
					n.tx_full = 1'b0;
					n = enter_byte(n, q.tx, q.step);
				end else if (q.step == digipot_host_pkg::STEP_READ && !q.rx_full) begin
					n = enter_byte(n, 8'h00, q.step);
				end
			end
			digipot_host_pkg::ST_STOP: begin
				if (tick_end) begin
					case (q.ph)
						2'h0: n.scl = 1'b1;
						2'h1: n.sda_oe = 1'b0;
						2'h2: n.scl = 1'b1;
						default: begin
							if (q.cmd[digipot_host_pkg::CMD_CODE_LSB +: 3] ==
									digipot_host_pkg::CODE_RESTORE && !q.auto_nop && !q.nack) begin
								// restore is chased by a no-operation to drop supply current
								n.auto_nop = 1'b1;
								n.cmd = {4'h0, 5'h00, digipot_host_pkg::CODE_NOP};
								n.left = 4'h0;
								n.step = digipot_host_pkg::STEP_ADDR_W;
								n = enter_cond(n, digipot_host_pkg::ST_START);
							end else begin
								n.auto_nop = 1'b0;
								n = enter_cond(n, digipot_host_pkg::ST_IDLE);
							end
						end
					endcase
				end
			end
			default: n = enter_cond(n, digipot_host_pkg::ST_IDLE);
		endcase

		if (apb_take && pwrite) begin
			case (paddr)
				digipot_host_pkg::OFF_CMD: begin
					// a command written while busy is dropped
					if (q.st == digipot_host_pkg::ST_IDLE) begin
						n.cmd = pwdata[11:0] & digipot_host_pkg::CMD_MASK;
						n.left = pwdata[digipot_host_pkg::CMD_CNT_LSB +: 4];
						n.nack = 1'b0;
						n.auto_nop = 1'b0;
						n.step = pwdata[digipot_host_pkg::CMD_SKIP_BIT] ?
							digipot_host_pkg::STEP_ADDR_R : digipot_host_pkg::STEP_ADDR_W;
						n = enter_cond(n, digipot_host_pkg::ST_START);
					end
				end
				digipot_host_pkg::OFF_SEL: begin
					if (q.st == digipot_host_pkg::ST_IDLE) begin
						n.sel = pwdata[1:0];
					end
				end
				digipot_host_pkg::OFF_DATA: begin
					n.tx = pwdata[7:0];
					n.tx_full = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			q <= '0;
			q.st <= digipot_host_pkg::ST_IDLE;
			q.step <= digipot_host_pkg::STEP_ADDR_W;
			q.scl <= 1'b1;
			q.cmd <= digipot_host_pkg::CMD_RST;
			q.sel <= digipot_host_pkg::SEL_RST;
		end else begin
			q <= n;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign scl = q.scl;
	assign sda_o = q.sda_o;
	assign sda_oe = q.sda_oe;
endmodule
`default_nettype wire

// ===== verilog/digipot_host_pkg.sv
package digipot_host_pkg;
	// bit timing: each scl period is split into four equal phases
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_NS = SCL_PERIOD_NS / 4;
	localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] QUARTER_LAST = 9'(QUARTER_CYC - 1);

	// register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_SEL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0C;

	// command register fields
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_DATA_BIT = 3;
	localparam int CMD_READ_BIT = 4;
	localparam int CMD_SKIP_BIT = 5;
	localparam int CMD_CNT_LSB = 8;
	localparam logic [11:0] CMD_MASK = 12'hF3F;
	localparam logic [11:0] CMD_RST = 12'h000;
	localparam logic [1:0] SEL_RST = 2'h0;

	// status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_TXF = 2;
	localparam int STAT_RXF = 3;
	localparam int STAT_AUTO = 4;
	localparam int STAT_RX_LSB = 8;

	// command_code_field values
	localparam logic [2:0] CODE_WIPER = 3'h0;
	localparam logic [2:0] CODE_NVSTORE = 3'h1;
	localparam logic [2:0] CODE_PROTECT = 3'h2;
	localparam logic [2:0] CODE_NOP = 3'h4;
	localparam logic [2:0] CODE_RESTORE = 3'h5;
	localparam logic [2:0] CODE_SAVE = 3'h6;
	localparam logic [4:0] INSTR_PAD = 5'h00;

	// bus addresses per addr_select_pin_one / addr_select_pin_zero strapping
	localparam logic [6:0] DEV_ADDR_LL = 7'h18;
	localparam logic [6:0] DEV_ADDR_P1 = 7'h1A;
	localparam logic [6:0] DEV_ADDR_P0 = 7'h4C;
	localparam logic [6:0] DEV_ADDR_HH = 7'h4E;

	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BYTE, ST_WAIT, ST_STOP} state_t;
	typedef enum logic [2:0] {STEP_ADDR_W, STEP_INSTR, STEP_DATA, STEP_ADDR_R, STEP_READ} step_t;

	// sel[1] is addr_select_pin_one, sel[0] is addr_select_pin_zero
	function automatic logic [6:0] dev_addr(input logic [1:0] sel);
		case (sel)
			2'h0: dev_addr = DEV_ADDR_LL;
			2'h2: dev_addr = DEV_ADDR_P1;
			2'h1: dev_addr = DEV_ADDR_P0;
			default: dev_addr = DEV_ADDR_HH;
		endcase
	endfunction
endpackage
